// ==== hdl/ipr_pkg.sv ====
// Package for the interrupt priority register bank.
// Assumes a 32-bit APB bus and 16-bit registers held in the low half-word.

package ipr_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned IPR_ADDR_W = 12;  // Byte address width
    localparam int unsigned IPR_DATA_W = 32;  // APB data width
    localparam int unsigned IPR_REG_W = 16;   // Implemented register width
    localparam int unsigned IPR_NUM_REGS = 6; // Registers in this bank
    localparam int unsigned IPR_NUM_SRC = 16; // Priority fields in this bank
    localparam int unsigned IPR_PRIO_W = 3;   // Width of one priority field

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] PRIO_UART2_INT2_TIMER5_OFF = 12'h000;
    localparam logic [11:0] PRIO_CAN_SPI2_OFF = 12'h004;
    localparam logic [11:0] PRIO_DMA_CH3_OFF = 12'h008;
    localparam logic [11:0] PRIO_DMA_CH4_PARALLEL_PORT_OFF = 12'h00c;
    localparam logic [11:0] PRIO_CALENDAR_DMA_CH5_OFF = 12'h010;
    localparam logic [11:0] PRIO_CRC_UART_ERRORS_OFF = 12'h014;

    // ------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------
    // Top bit set, lower two clear: level four after reset
    localparam logic [2:0] IPR_PRIO_RESET = 3'h4;
    // Zero means the source is switched off
    localparam logic [2:0] IPR_PRIO_OFF = 3'h0;

    // ------------------------------------------------------------
    // Source indices, in register order
    // ------------------------------------------------------------
    localparam int unsigned SRC_UART2_TX = 0;
    localparam int unsigned SRC_UART2_RX = 1;
    localparam int unsigned SRC_EXT_IRQ2 = 2;
    localparam int unsigned SRC_TIMER5 = 3;
    localparam int unsigned SRC_CAN_EVENT = 4;
    localparam int unsigned SRC_CAN_RX_READY = 5;
    localparam int unsigned SRC_SPI2_EVENT = 6;
    localparam int unsigned SRC_SPI2_ERROR = 7;
    localparam int unsigned SRC_DMA_CH3_DONE = 8;
    localparam int unsigned SRC_DMA_CH4_DONE = 9;
    localparam int unsigned SRC_PARALLEL_PORT = 10;
    localparam int unsigned SRC_CALENDAR = 11;
    localparam int unsigned SRC_DMA_CH5_DONE = 12;
    localparam int unsigned SRC_CRC_ERROR = 13;
    localparam int unsigned SRC_UART2_ERROR = 14;
    localparam int unsigned SRC_UART1_ERROR = 15;

    // ------------------------------------------------------------
    // Field layout: register index and low bit of each source
    // ------------------------------------------------------------
    localparam int unsigned IPR_FIELD_REG [16] = '{
        0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 5, 5, 5};
    localparam int unsigned IPR_FIELD_LSB [16] = '{
        12, 8, 4, 0, 12, 8, 4, 0, 0, 8, 4, 8, 4, 12, 8, 4};

endpackage : ipr_pkg

// ==== hdl/ipr_field_if.sv ====
// Interface between the register bank and one priority field.
// Assumes the bank drives clock, reset and write strobe for each field.

interface ipr_field_if;
    logic clk;             // Register clock
    logic rst_n;           // Asynchronous reset, active low
    logic ce;              // Clock enable, freezes the field when low
    logic wr_en;           // Write strobe, one cycle
    logic [2:0] wr_data;   // New field value
    logic [2:0] value;     // Stored field value

    modport ctrl (
        output clk,
        output rst_n,
        output ce,
        output wr_en,
        output wr_data,
        input value
    );

    modport field (
        input clk,
        input rst_n,
        input ce,
        input wr_en,
        input wr_data,
        output value
    );
endinterface : ipr_field_if

// ==== hdl/ipr_field.sv ====
// One three-bit priority field with its reset value.
// Assumes the bank only strobes a write at the APB completion edge.

module ipr_field
(
    ipr_field_if.field bus
);
    import ipr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] value;  // Stored priority level
    } ipr_field_state_t;

    ipr_field_state_t r;       // Current state
    ipr_field_state_t next_r;  // Next state

    // Next value: a write replaces all three bits
    always_comb
    begin
        next_r = r;
        if (bus.wr_en)
        begin
            next_r.value = bus.wr_data;
        end
    end

    // Register; reset leaves level four, top bit set
    always_ff @(posedge bus.clk or negedge bus.rst_n)
    begin
        if (!bus.rst_n)
        begin
            r.value <= IPR_PRIO_RESET;
        end
        else if (bus.ce)
        begin
            r <= next_r;
        end
    end

    assign bus.value = r.value;
endmodule : ipr_field

// ==== hdl/ipr_top.sv ====
// Interrupt priority register bank behind an APB slave port.
// Assumes an APB master on pclk and a CAN-present strap from a pin.
//
// What this block does
// - Three-bit fields; seven is the highest level
// - One is lowest; values map to levels
// - Zero disables its source completely
// - Reset sets field top bit, clears others
// - Unimplemented and spacer bits read zero
// - First register: UART2 tx/rx, irq2, timer5
// - Second register: CAN event/rx, SPI2 event/error
// - CAN sources off without CAN, three edges after release or strap drop
// - Third register: only DMA channel 3 field
// - Fourth register: DMA channel 4, parallel port
// - Fifth register: calendar, DMA channel 5
// - Sixth register: CRC, UART2 and UART1 errors
// - Every source starts at level four

module ipr_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ipr_pkg::IPR_ADDR_W-1:0] paddr,
    input wire logic [ipr_pkg::IPR_DATA_W-1:0] pwdata,
    output logic [ipr_pkg::IPR_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic can_present,
    output logic [15:0][2:0] src_priority,
    output logic [15:0] src_active
);
    import ipr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic can_meta;          // First strap synchroniser stage
        logic can_sync;          // Second strap synchroniser stage
        logic pready;            // Access phase answer
        logic pslverr;           // Unmapped or unaligned access
        logic [31:0] prdata;     // Read data held for the master
        logic [15:0][2:0] prio;  // Effective level per source
        logic [15:0] active;     // Source may be presented
    } ipr_top_state_t;

    ipr_top_state_t r;       // Current state
    ipr_top_state_t next_r;  // Next state

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic [2:0] sel;        // Register index selected by paddr
    logic sel_ok;           // Address hits a register
    logic setup;            // APB setup cycle
    logic wr_fire;          // Write completes at this edge
    logic [15:0][2:0] field_val;  // Stored field values
    logic [15:0] rd_word;   // Read view of the selected register

    // Decode byte address to a register index
    always_comb
    begin
        sel = 3'h0;
        sel_ok = 1'b1;
        case (paddr)
            PRIO_UART2_INT2_TIMER5_OFF:
            begin
                sel = 3'h0;
            end
            PRIO_CAN_SPI2_OFF:
            begin
                sel = 3'h1;
            end
            PRIO_DMA_CH3_OFF:
            begin
                sel = 3'h2;
            end
            PRIO_DMA_CH4_PARALLEL_PORT_OFF:
            begin
                sel = 3'h3;
            end
            PRIO_CALENDAR_DMA_CH5_OFF:
            begin
                sel = 3'h4;
            end
            PRIO_CRC_UART_ERRORS_OFF:
            begin
                sel = 3'h5;
            end
            default:
            begin
                // Unaligned or outside the bank
                sel_ok = 1'b0;
            end
        endcase
    end

    // Setup cycle starts every transfer
    assign setup = psel & ~penable;

    // Write lands only at the edge that completes the access
    assign wr_fire = ce & psel & penable & r.pready & pwrite & ~r.pslverr;

    // ------------------------------------------------------------
    // Priority fields
    // ------------------------------------------------------------
    ipr_field_if fif[IPR_NUM_SRC] ();

    genvar g;
    generate
        for (g = 0; g < IPR_NUM_SRC; g++)
        begin : g_field
            // Shared clock, reset and enable
            assign fif[g].clk = pclk;
            assign fif[g].rst_n = presetn;
            assign fif[g].ce = ce;
            // Strobe only the field that lives in the selected register
            assign fif[g].wr_en = wr_fire &
                (sel == 3'(IPR_FIELD_REG[g]));
            // Only the three field bits are taken; the rest is dropped
            assign fif[g].wr_data =
                pwdata[IPR_FIELD_LSB[g] +: IPR_PRIO_W];
            assign field_val[g] = fif[g].value;

            ipr_field u_field
            (
                .bus (fif[g].field)
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    // Assemble the selected register; all other bits stay zero
    always_comb
    begin
        rd_word = 16'h0000;
        for (int i = 0; i < IPR_NUM_SRC; i++)
        begin
            if (sel == 3'(IPR_FIELD_REG[i]))
            begin
                // Fields sit at fixed low bits, spacer above
                rd_word[IPR_FIELD_LSB[i] +: IPR_PRIO_W] =
                    field_val[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Bus answer, strap sampling and effective levels
    always_comb
    begin
        next_r = r;

        // Strap passes two flops before anything looks at it
        next_r.can_meta = can_present;
        next_r.can_sync = r.can_meta;

        // Answer one cycle after setup; access lasts one cycle
        next_r.pready = setup;
        // Error stands only beside ready, never left over
        next_r.pslverr = 1'b0;
        if (setup)
        begin
            // Capture read data and error in the setup cycle
            next_r.pslverr = ~sel_ok;
            if (sel_ok && !pwrite)
            begin
                next_r.prdata = {16'h0000, rd_word};
            end
            else
            begin
                // Writes and errors read back zero
                next_r.prdata = 32'h0000_0000;
            end
        end

        // Effective level per source, as the arbiter sees it
        for (int i = 0; i < IPR_NUM_SRC; i++)
        begin
            next_r.prio[i] = field_val[i];
        end

        // Without CAN hardware both CAN sources are held off
        if (!r.can_sync)
        begin
            next_r.prio[SRC_CAN_EVENT] = IPR_PRIO_OFF;
            next_r.prio[SRC_CAN_RX_READY] = IPR_PRIO_OFF;
        end

        // Zero level keeps the source from ever being presented
        for (int i = 0; i < IPR_NUM_SRC; i++)
        begin
            next_r.active[i] = (next_r.prio[i] != IPR_PRIO_OFF);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset assumes CAN present so levels match the fields at once;
    // a missing CAN forces its levels off three edges after release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r.can_meta <= 1'b1;
            r.can_sync <= 1'b1;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.prdata <= 32'h0000_0000;
            r.prio <= {IPR_NUM_SRC{IPR_PRIO_RESET}};
            r.active <= 16'hffff;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All outputs come straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign src_priority = r.prio;
    assign src_active = r.active;
endmodule : ipr_top

// ==== verification/ipr_chk.sv ====
// Port checker for the priority register bank.
// Assumes binding to ipr_top, one clock domain.

module ipr_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic can_present,
    input wire logic [15:0][2:0] src_priority,
    input wire logic [15:0] src_active
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Sequences and helpers
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable && ce;
    endsequence
    // Completed write to the first register
    sequence wr_first;
        ce && psel && penable && pready && pwrite && !pslverr &&
            paddr == 12'h000;
    endsequence
    logic [15:0] act_exp; // Active flags implied by levels
    // Non-zero level means the source may be served
    always_comb
        for (int i = 0; i < 16; i++)
            act_exp[i] = |src_priority[i];

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    ready_after_setup_a: assert property (apb_setup |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready && ce |=> !pready)
        else $error("ready held too long");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper half not zero");
    spacer_zero_a: assert property (pready |->
        (prdata & 32'h8888) == 32'h0) else $error("spacer bit set");
    unmapped_err_a: assert property (apb_setup ##0 paddr > 12'h014
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    mapped_ok_a: assert property (apb_setup ##0
        (paddr <= 12'h014 && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped access refused");
    write_seen_a: assert property (wr_first |->
        ##2 src_priority[0] == $past(pwdata[14:12], 2))
        else $error("written level not seen");
    active_match_a: assert property (src_active == act_exp)
        else $error("active flags wrong");
    can_off_a: assert property ((!can_present && ce)[*3] |=>
        src_priority[4] == 3'h0 && src_priority[5] == 3'h0)
        else $error("CAN sources not off");
    level_four_a: assert property ($rose(presetn) |->
        src_priority == {16{3'h4}}) else $error("reset level wrong");
    // A refused access flags its error only in the ready cycle
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Clock enable low freezes the levels, ready and read data outputs
    freeze_hold_a: assert property (!ce |=>
        $stable(src_priority) && $stable(pready) && $stable(prdata))
        else $error("state moved while frozen");
endmodule : ipr_chk

// ==== verification/test_interrupt_priority_regs.sv ====
// Self-checking bench for the priority register bank.
// Assumes the APB slave answers after one access cycle.

module test_interrupt_priority_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import ipr_pkg::*;
    logic pclk = 1'b0; // 10 MHz bus clock
    logic presetn = 1'b0;
    logic ce = 1'b1; // Running; lowered once to check the freeze
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic can_present = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0][2:0] src_priority;
    logic [15:0] src_active;
    logic [2:0] exp_f [16]; // Expected stored levels
    logic [15:0] pats [4] = '{16'hffff, 16'h1111, 16'h0000, 16'hd6b2};
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int cmp_count = 0;

    always #50 pclk = ~pclk;

    ipr_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .can_present(can_present), .src_priority(src_priority),
        .src_active(src_active));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string what, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // One APB transfer, entered just after a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // Idle cycle keeps strobes from clashing
    endtask : xfer

    // Register image built from the expected fields
    function logic [15:0] reg_val(input int r);
        logic [15:0] v;
        v = 16'h0;
        for (int i = 0; i < 16; i++)
            if (IPR_FIELD_REG[i] == r)
                v[IPR_FIELD_LSB[i] +: 3] = exp_f[i];
        return v;
    endfunction : reg_val

    task write_reg(input int r, input logic [15:0] d);
        xfer(1'b1, 12'(4 * r), d);
        chk("write error", 48'h0, 48'(err));
        for (int i = 0; i < 16; i++)
            if (IPR_FIELD_REG[i] == r)
                exp_f[i] = d[IPR_FIELD_LSB[i] +: 3];
    endtask : write_reg

    // Read every register, then compare levels and active flags
    task check_all();
        logic [47:0] ep;
        logic [15:0] ea;
        for (int r = 0; r < 6; r++)
        begin
            xfer(1'b0, 12'(4 * r), 16'h0);
            chk("read data", {32'h0, reg_val(r)}, 48'(rd));
            chk("read error", 48'h0, 48'(err));
        end
        for (int i = 0; i < 16; i++)
        begin
            ep[3*i +: 3] = exp_f[i];
            // Without CAN both CAN levels read as switched off
            if (!can_present && (i == 4 || i == 5))
                ep[3*i +: 3] = 3'h0;
            ea[i] = |ep[3*i +: 3];
        end
        chk("levels", ep, src_priority);
        chk("active", 48'(ea), 48'(src_active));
    endtask : check_all

    task do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (exp_f[i])
            exp_f[i] = IPR_PRIO_RESET;
    endtask : do_reset

    task end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        @(posedge pclk);
        do_reset();
        check_all();
        foreach (pats[p])
        begin
            for (int r = 0; r < 6; r++)
                write_reg(r, pats[p]);
            check_all();
        end
        xfer(1'b0, 12'h018, 16'h0);
        chk("unmapped read", 48'h1, {rd, 15'h0, err});
        xfer(1'b1, 12'h018, 16'hffff);
        chk("unmapped write", 48'h1, 48'(err));
        xfer(1'b0, 12'h002, 16'h0);
        chk("unaligned read", 48'h1, 48'(err));
        check_all();
        // Strap drops while frozen: levels must not move yet
        ce <= 1'b0;
        can_present <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("frozen level", 48'(exp_f[4]), 48'(src_priority[4]));
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        check_all();
        can_present <= 1'b1;
        repeat (4) @(posedge pclk);
        do_reset();
        check_all();
        end_of_test();
    end

    // Whole run is a few hundred cycles
    initial
    begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
endmodule : test_interrupt_priority_regs

bind ipr_top ipr_chk chk (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_present(can_present), .src_priority(src_priority),
    .src_active(src_active));
